// ---- hw/hpc_pkg.sv ----
`default_nettype none
package hpc_pkg;
    // register map, byte addresses on the bus
    localparam int unsigned ADDR_W        = 9;
    localparam logic [8:0]  OFS_CONTROL   = 9'h000;
    localparam logic [8:0]  OFS_STATUS    = 9'h004;
    localparam logic [8:0]  OFS_COUNTER   = 9'h008;
    localparam logic [8:0]  OFS_MATCH0    = 9'h00C;
    localparam logic [8:0]  OFS_MATCH1    = 9'h010;
    localparam logic [8:0]  OFS_LOAD      = 9'h014;
    localparam logic [8:0]  OFS_TRIM      = 9'h018;
    localparam logic [8:0]  OFS_DATA_BASE = 9'h100;
    localparam int unsigned DATA_WORDS    = 64;

    // control register fields
    localparam int unsigned CTL_RTC_ENABLE   = 0;
    localparam int unsigned CTL_HIB_REQUEST  = 1;
    localparam int unsigned CTL_CLK_ENABLE   = 2;
    localparam int unsigned CTL_PIN_WAKE     = 3;
    localparam int unsigned CTL_MATCH_WAKE   = 4;
    localparam int unsigned CTL_LOWBAT_DET   = 5;
    localparam int unsigned CTL_LOWBAT_ABORT = 6;
    localparam int unsigned CTL_CLK_SELECT   = 7;
    localparam int unsigned CTL_WIDTH        = 8;
    localparam logic [7:0]  CONTROL_RESET    = 8'h00;

    // status register fields
    localparam int unsigned STS_LOWBAT      = 0;
    localparam int unsigned STS_PIN_WAKE    = 1;
    localparam int unsigned STS_MATCH0      = 2;
    localparam int unsigned STS_MATCH1      = 3;
    localparam int unsigned STS_HIBERNATING = 4;
    localparam int unsigned STS_PENDING     = 5;
    localparam int unsigned STS_ABORTED     = 6;
    localparam int unsigned STS_WIDTH       = 7;

    // slow clock and real-time counter
    localparam int unsigned CRYSTAL_DIVIDE  = 128;
    localparam logic [14:0] PREDIV_NOMINAL  = 15'h7FFF;
    localparam logic [31:0] TRIM_RESET      = 32'h0000_7FFF;
    localparam int unsigned TRIM_PERIOD     = 64;

    // main-domain reset stretch after power returns
    localparam int unsigned MCLK_PERIOD_NS  = 8;
    localparam int unsigned POR_TIME_NS     = 1000;
    localparam int unsigned POR_CYCLES      = (POR_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    typedef enum logic [1:0] {ST_AWAKE, ST_HIBERNATE, ST_POWER_UP} hpc_state_type;
endpackage
`default_nettype wire

// ---- hw/hpc_slow_if.sv ----
`default_nettype none
interface hpc_slow_if;
    logic enable;
    logic select;
    logic tick;
    logic osc_out;
    modport gen  (input enable, input select, output tick, output osc_out);
    modport user (output enable, output select, input tick, input osc_out);
endinterface
`default_nettype wire

// ---- hw/hpc_slow_clock.sv ----
`default_nettype none
module hpc_slow_clock import hpc_pkg::*; #(
    parameter int unsigned DIVIDE = CRYSTAL_DIVIDE
) (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic slow_osc_in,
    hpc_slow_if.gen   slow
);
    localparam int unsigned DW = $clog2(DIVIDE);

    logic          osc_prev_reg;
    logic [DW-1:0] div_reg;
    logic          tick_reg;
    logic          osc_out_reg;
    logic          osc_rise;

    // edge of the oscillator pin, sampled on mclk
    always_ff @(posedge mclk) begin
        osc_prev_reg <= reset ? 1'b0 : slow_osc_in;
    end
    assign osc_rise = slow_osc_in & ~osc_prev_reg;

    // crystal prescaler, idle while the source is off
    always_ff @(posedge mclk) begin
        if (reset || !slow.enable) begin
            div_reg <= '0;
        end else if (osc_rise) begin
            div_reg <= (div_reg == DW'(DIVIDE - 1)) ? '0 : div_reg + 1'b1;
        end
    end

    // one tick per slow reference period; nothing runs until enabled
    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= slow.enable & osc_rise & (slow.select | (div_reg == DW'(DIVIDE - 1)));
        end
    end

    // crude inverting drive for the crystal, quiet in oscillator mode
    always_ff @(posedge mclk) begin
        osc_out_reg <= reset ? 1'b0 : (slow.enable & ~slow.select & ~slow_osc_in);
    end

    assign slow.tick    = tick_reg;
    assign slow.osc_out = osc_out_reg;

    AST_CRYSTAL_DIVIDE: assert property (@(posedge mclk) disable iff (reset)
        (tick_reg && !slow.select && $past(slow.enable)) |-> (div_reg == '0 && $past(div_reg) == DW'(DIVIDE - 1)))
        else $error("crystal tick not on the divide boundary");
endmodule // hpc_slow_clock
`default_nettype wire

// ---- hw/hpc_wake_sync.sv ----
`default_nettype none
module hpc_wake_sync (
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic wake_n,
    output logic      wake_active
);
    logic sync_a_reg;
    logic sync_b_reg;

    // two-stage synchroniser; idle level of the pin is high
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync_a_reg <= 1'b1;
            sync_b_reg <= 1'b1;
        end else begin
            sync_a_reg <= wake_n;
            sync_b_reg <= sync_a_reg;
        end
    end
    assign wake_active = ~sync_b_reg;
endmodule // hpc_wake_sync
`default_nettype wire

// ---- hw/hpc_top.sv ----
`default_nettype none
module hpc_top import hpc_pkg::*; #(
    parameter int unsigned WORDS = DATA_WORDS
) (
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              wake_n,
    input  wire logic              low_battery,
    input  wire logic              slow_osc_in,
    output logic                   slow_osc_out,
    input  wire logic              power_off_n_i,
    output logic                   power_off_n_o,
    output logic                   power_off_n_oe_n,
    output logic                   main_reset
);
    localparam int unsigned PW = $clog2(POR_CYCLES + 1);

    hpc_slow_if slow ();

    hpc_state_type            state_reg;
    logic [CTL_WIDTH-1:0]     control_reg;
    logic [STS_WIDTH-1:0]     events_reg;
    logic [31:0]              counter_reg;
    logic [31:0]              match0_reg;
    logic [31:0]              match1_reg;
    logic [31:0]              trim_reg;
    logic [31:0]              backup_mem [WORDS];
    logic [14:0]              prediv_reg;
    logic [5:0]               seconds_reg;
    logic                     pend_reg;
    logic [ADDR_W-1:0]        pend_adr_reg;
    logic [31:0]              pend_dat_reg;
    logic [3:0]               pend_sel_reg;
    logic [PW-1:0]            por_cnt_reg;
    logic                     ack_reg;
    logic [31:0]              rdata_reg;
    logic                     wake_active;
    logic                     bus_req;
    logic                     bus_wr;
    logic                     hib_enter;
    logic                     hib_abort;
    logic                     match0_hit;
    logic                     match1_hit;
    logic                     pin_wake;
    logic                     match_wake;
    logic                     sts_clear_wr;
    logic [STS_WIDTH-1:0]     sts_clear;

    // byte-lane merge used for every posted slow-register write except OFS_COUNTER, which is dropped
    function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // registers that live behind the slow clock and need the posted path
    function automatic logic is_slow_reg(input logic [ADDR_W-1:0] adr);
        return adr == OFS_COUNTER || adr == OFS_MATCH0 || adr == OFS_MATCH1 ||
               adr == OFS_LOAD || adr == OFS_TRIM || adr >= OFS_DATA_BASE;
    endfunction

    hpc_slow_clock #(.DIVIDE(CRYSTAL_DIVIDE)) u_slow_clock (
        .mclk        (mclk),
        .reset       (reset),
        .slow_osc_in (slow_osc_in),
        .slow        (slow)
    );

    hpc_wake_sync u_wake_sync (
        .mclk        (mclk),
        .reset       (reset),
        .wake_n      (wake_n),
        .wake_active (wake_active)
    );

    assign slow.enable  = control_reg[CTL_CLK_ENABLE];
    assign slow.select  = control_reg[CTL_CLK_SELECT];
    assign slow_osc_out = slow.osc_out;

    // bus strobes
    assign bus_req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr       = bus_req & wb_we_i;
    assign sts_clear_wr = bus_wr && wb_adr_i == OFS_STATUS;
    assign sts_clear    = sts_clear_wr ? wb_dat_i[STS_WIDTH-1:0] : '0;

    // entry decisions
    assign hib_abort  = control_reg[CTL_LOWBAT_DET] & control_reg[CTL_LOWBAT_ABORT] & low_battery;
    assign hib_enter  = state_reg == ST_AWAKE && control_reg[CTL_HIB_REQUEST];
    assign match0_hit = counter_reg == match0_reg;
    assign match1_hit = counter_reg == match1_reg;
    // wake sources act on the slow tick, so a stopped slow clock never wakes
    assign pin_wake   = slow.tick & control_reg[CTL_PIN_WAKE] & wake_active;
    assign match_wake = slow.tick & control_reg[CTL_MATCH_WAKE] & (match0_hit | match1_hit);

    // one-cycle ack for every access; reads never wait
    always_ff @(posedge mclk) begin
        ack_reg <= reset ? 1'b0 : bus_req;
    end
    assign wb_ack_o = ack_reg;

    // read data, unmapped addresses read zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            if (wb_adr_i >= OFS_DATA_BASE) begin
                rdata_reg <= backup_mem[wb_adr_i[$clog2(WORDS)+1:2]];
            end else begin
                case (wb_adr_i)
                    OFS_CONTROL: rdata_reg <= {{(32-CTL_WIDTH){1'b0}}, control_reg};
                    OFS_STATUS:  rdata_reg <= {{(32-STS_WIDTH){1'b0}}, events_reg};
                    OFS_COUNTER: rdata_reg <= counter_reg;
                    OFS_MATCH0:  rdata_reg <= match0_reg;
                    OFS_MATCH1:  rdata_reg <= match1_reg;
                    OFS_LOAD:    rdata_reg <= counter_reg;
                    OFS_TRIM:    rdata_reg <= trim_reg;
                    default:     rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_dat_o = rdata_reg;

    // control register; the request bit is consumed by the sequencer
    always_ff @(posedge mclk) begin
        if (reset) begin
            control_reg <= CONTROL_RESET;
        end else if (bus_wr && wb_adr_i == OFS_CONTROL && wb_sel_i[0]) begin
            control_reg <= wb_dat_i[CTL_WIDTH-1:0];
        end else if (state_reg == ST_AWAKE) begin
            control_reg[CTL_HIB_REQUEST] <= 1'b0;
        end
    end

    // posted write slot; a second write before the tick overwrites it
    always_ff @(posedge mclk) begin
        if (reset) begin
            pend_reg     <= 1'b0;
            pend_adr_reg <= '0;
            pend_dat_reg <= 32'h0000_0000;
            pend_sel_reg <= 4'h0;
        end else if (bus_wr && is_slow_reg(wb_adr_i)) begin
            pend_reg     <= 1'b1;
            pend_adr_reg <= wb_adr_i;
            pend_dat_reg <= wb_dat_i;
            pend_sel_reg <= wb_sel_i;
        end else if (slow.tick) begin
            pend_reg     <= 1'b0;
        end
    end

    // slow-domain registers take the posted write on the tick
    always_ff @(posedge mclk) begin
        if (reset) begin
            match0_reg <= 32'h0000_0000;
            match1_reg <= 32'h0000_0000;
            trim_reg   <= TRIM_RESET;
        end else if (slow.tick && pend_reg) begin
            case (pend_adr_reg)
                OFS_MATCH0: match0_reg <= byte_merge(match0_reg, pend_dat_reg, pend_sel_reg);
                OFS_MATCH1: match1_reg <= byte_merge(match1_reg, pend_dat_reg, pend_sel_reg);
                OFS_TRIM:   trim_reg   <= byte_merge(trim_reg, pend_dat_reg, pend_sel_reg);
                default:    trim_reg   <= trim_reg;
            endcase
        end
    end

    // backup words, kept across hibernation; no reset on purpose
    always_ff @(posedge mclk) begin
        if (slow.tick && pend_reg && pend_adr_reg >= OFS_DATA_BASE) begin
            backup_mem[pend_adr_reg[$clog2(WORDS)+1:2]] <=
                byte_merge(backup_mem[pend_adr_reg[$clog2(WORDS)+1:2]], pend_dat_reg, pend_sel_reg);
        end
    end

    // predivider: trimmed length once every sixty-four seconds
    always_ff @(posedge mclk) begin
        if (reset) begin
            prediv_reg  <= PREDIV_NOMINAL;
            seconds_reg <= 6'h00;
        end else if (slow.tick && control_reg[CTL_RTC_ENABLE]) begin
            if (prediv_reg == 15'h0000) begin
                seconds_reg <= seconds_reg + 6'h01;
                prediv_reg  <= (seconds_reg == 6'(TRIM_PERIOD - 1)) ? trim_reg[14:0] : PREDIV_NOMINAL;
            end else begin
                prediv_reg  <= prediv_reg - 15'h0001;
            end
        end
    end

    // seconds counter; a load takes precedence over the increment
    always_ff @(posedge mclk) begin
        if (reset) begin
            counter_reg <= 32'h0000_0000;
        end else if (slow.tick && pend_reg && pend_adr_reg == OFS_LOAD) begin
            counter_reg <= byte_merge(counter_reg, pend_dat_reg, pend_sel_reg);
        end else if (slow.tick && control_reg[CTL_RTC_ENABLE] && prediv_reg == 15'h0000) begin
            counter_reg <= counter_reg + 32'h0000_0001;
        end
    end

    // status: events sticky, hibernating and pending live; a new event wins over a write-one clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            events_reg <= '0;
        end else begin
            events_reg[STS_LOWBAT]   <= (control_reg[CTL_LOWBAT_DET] & low_battery & state_reg != ST_HIBERNATE)
                                        | (events_reg[STS_LOWBAT] & ~sts_clear[STS_LOWBAT]);
            events_reg[STS_PIN_WAKE] <= pin_wake | (events_reg[STS_PIN_WAKE] & ~sts_clear[STS_PIN_WAKE]);
            events_reg[STS_MATCH0]   <= (slow.tick & match0_hit) | (events_reg[STS_MATCH0] & ~sts_clear[STS_MATCH0]);
            events_reg[STS_MATCH1]   <= (slow.tick & match1_hit) | (events_reg[STS_MATCH1] & ~sts_clear[STS_MATCH1]);
            events_reg[STS_HIBERNATING] <= state_reg == ST_HIBERNATE;
            events_reg[STS_PENDING]     <= pend_reg;
            events_reg[STS_ABORTED]  <= (hib_enter & hib_abort) | (events_reg[STS_ABORTED] & ~sts_clear[STS_ABORTED]);
        end
    end

    // hibernation sequencer
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= ST_AWAKE;
        end else begin
            case (state_reg)
                ST_AWAKE: begin
                    if (hib_enter && !hib_abort) begin
                        state_reg <= ST_HIBERNATE;
                    end
                end
                ST_HIBERNATE: begin
                    if (pin_wake || match_wake) begin
                        state_reg <= ST_POWER_UP;
                    end
                end
                ST_POWER_UP: begin
                    if (por_cnt_reg == PW'(POR_CYCLES - 1)) begin
                        state_reg <= ST_AWAKE;
                    end
                end
                default: state_reg <= ST_AWAKE;
            endcase
        end
    end

    // length of the main-domain reset after power returns
    always_ff @(posedge mclk) begin
        if (reset || state_reg != ST_POWER_UP) begin
            por_cnt_reg <= '0;
        end else begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
        end
    end

    // pin drives low only while hibernating, otherwise the pull-up wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            power_off_n_oe_n <= 1'b1;
            main_reset       <= 1'b0;
        end else begin
            power_off_n_oe_n <= ~((hib_enter & ~hib_abort) | (state_reg == ST_HIBERNATE & ~pin_wake & ~match_wake));
            main_reset       <= (hib_enter & ~hib_abort) | state_reg == ST_HIBERNATE
                                | (state_reg == ST_POWER_UP && por_cnt_reg != PW'(POR_CYCLES - 1));
        end
    end
    assign power_off_n_o = 1'b0;

    sequence seq_wake_edge;
        state_reg == ST_HIBERNATE && (pin_wake || match_wake);
    endsequence

    sequence seq_power_return;
        ##1 (main_reset && power_off_n_oe_n)[*8];
    endsequence

    AST_OFF_WHILE_HIB: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ST_HIBERNATE |-> !power_off_n_oe_n && power_off_n_i == 1'b0)
        else $error("power-off pin not driven low in hibernation");
    AST_RELEASE_AWAKE: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ST_AWAKE && $past(state_reg) == ST_AWAKE |-> power_off_n_oe_n)
        else $error("power-off pin driven while awake");
    AST_PIN_WAKE: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ST_HIBERNATE && slow.tick && control_reg[CTL_PIN_WAKE] && wake_active
        |=> state_reg == ST_POWER_UP && power_off_n_oe_n)
        else $error("pin wake ignored");
    AST_MATCH_WAKE: assert property (@(posedge mclk) disable iff (reset)
        state_reg == ST_HIBERNATE && slow.tick && control_reg[CTL_MATCH_WAKE] && counter_reg == match1_reg
        |=> state_reg == ST_POWER_UP)
        else $error("match wake ignored");
    AST_POR_AFTER_WAKE: assert property (@(posedge mclk) disable iff (reset)
        seq_wake_edge |-> seq_power_return)
        else $error("main reset not held after power return");
    AST_ABORT_LOWBAT: assert property (@(posedge mclk) disable iff (reset)
        hib_enter && control_reg[CTL_LOWBAT_DET] && control_reg[CTL_LOWBAT_ABORT] && low_battery
        |=> state_reg == ST_AWAKE && power_off_n_oe_n && events_reg[STS_ABORTED])
        else $error("hibernation entered on low battery");
    AST_ENTER_ON_REQUEST: assert property (@(posedge mclk) disable iff (reset)
        hib_enter && !hib_abort |=> state_reg == ST_HIBERNATE && !power_off_n_oe_n && main_reset)
        else $error("request did not start hibernation");
    AST_READ_ACK: assert property (@(posedge mclk) disable iff (reset)
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o |=> wb_ack_o)
        else $error("read not answered in one cycle");
    AST_POSTED_WRITE: assert property (@(posedge mclk) disable iff (reset)
        pend_reg && slow.tick && !bus_wr |=> !pend_reg)
        else $error("posted write not retired on tick");
endmodule // hpc_top
`default_nettype wire

// ---- dv/hpc_far_side.sv ----
`default_nettype none
module hpc_far_side (
    input  wire logic power_off_n_oe_n,
    input  wire logic power_off_n_o,
    input  wire logic wake_req,
    input  wire logic xtal_mode,
    output logic      slow_osc_in,
    output logic      wake_n,
    output logic      power_off_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // crystal at 4.194304 MHz or dedicated 32.768 kHz oscillator, both free running
    initial begin
        slow_osc_in = 1'b0;
        forever begin
            #(xtal_mode ? 119.209 : 15258.789) slow_osc_in = ~slow_osc_in;
        end
    end
    // pull-up wins unless the device sinks the pin with its open-drain value
    assign power_off_n_i = power_off_n_oe_n ? 1'b1 : power_off_n_o;
    assign wake_n = ~wake_req;
endmodule // hpc_far_side
`default_nettype wire

// ---- dv/tb_hpc_top.sv ----
`default_nettype none
module tb_hpc_top import hpc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [8:0]  adr = 9'h000;
    logic [31:0] wdat = 32'h0;
    logic        wake_req = 1'b0;
    logic        low_bat = 1'b0;
    logic        xtal_mode = 1'b1;
    logic [31:0] rdat;
    logic        ack, osc, osc_out, wake_n, pin_i, pwr_o, oe_n, mrst;
    // crystal settle wait in mclk cycles, a bench value chosen freely
    localparam int CRYSTAL_SETTLE_TIME = 200;
    int          fails = 0;
    int          cmp_count = 0;

    // 125 MHz
    always #4 mclk = ~mclk;

    hpc_top i_hpc_top (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wake_n(wake_n), .low_battery(low_bat), .slow_osc_in(osc),
        .slow_osc_out(osc_out), .power_off_n_i(pin_i), .power_off_n_o(pwr_o),
        .power_off_n_oe_n(oe_n), .main_reset(mrst));

    hpc_far_side i_hpc_far_side (.power_off_n_oe_n(oe_n), .power_off_n_o(pwr_o), .wake_req(wake_req),
        .xtal_mode(xtal_mode), .slow_osc_in(osc), .wake_n(wake_n), .power_off_n_i(pin_i));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until ack is sampled, then released; only the watchdog ends a wait
    task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_m(input logic [8:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    // slow writes land on a slow tick; poll the pending flag before next access
    task automatic settle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, OFS_STATUS, 32'h0, q);
            n++;
        end while (q[STS_PENDING] !== 1'b0 && n < 3000);
        chk(32'(q[STS_PENDING]), 32'h0);
    endtask

    task automatic wait_pin(input logic lvl);
        int n;
        n = 0;
        while (pin_i !== lvl && n < 10000) begin
            @(posedge mclk);
            n++;
        end
        chk(32'(pin_i), 32'(lvl));
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard, about twice the worst case of the slow ticks waited for
    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        rd_m(OFS_CONTROL, 32'hFFFF_FFFF, 32'h0);
        rd_m(OFS_TRIM, 32'hFFFF_FFFF, TRIM_RESET);
        rd_m(9'h0FC, 32'hFFFF_FFFF, 32'h0);
        chk(32'(osc_out), 32'h0);
        chk(32'(pin_i), 32'h1);
        // crystal first: select at zero, then stay off the bus while it settles
        wr(OFS_CONTROL, 32'h04);
        repeat (CRYSTAL_SETTLE_TIME) @(posedge mclk);
        @(negedge osc);
        repeat (2) @(posedge mclk);
        chk(32'(osc_out), 32'h1);
        rd_m(OFS_CONTROL, 32'hFFFF_FFFF, 32'h04);
        wr(OFS_MATCH1, 32'h0000_0003);
        settle();
        rd_m(OFS_MATCH1, 32'hFFFF_FFFF, 32'h3);
        // dedicated oscillator: no settle wait, crystal drive goes quiet
        xtal_mode <= 1'b0;
        wr(OFS_CONTROL, 32'h84);
        rd_m(OFS_CONTROL, 32'hFFFF_FFFF, 32'h84);
        chk(32'(osc_out), 32'h0);
        wr(OFS_DATA_BASE + 9'h004, 32'hA5C3_0F96);
        settle();
        rd_m(OFS_DATA_BASE + 9'h004, 32'hFFFF_FFFF, 32'hA5C3_0F96);
        // low battery with abort must refuse entry
        low_bat <= 1'b1;
        wr(OFS_CONTROL, 32'hEE);
        repeat (20) @(posedge mclk);
        chk(32'(oe_n), 32'h1);
        rd_m(OFS_STATUS, 32'h51, 32'h41);
        low_bat <= 1'b0;
        wr(OFS_STATUS, 32'h7F);
        // pin wake only; match0 equals counter but its wake is off
        wr(OFS_CONTROL, 32'h8E);
        repeat (2) @(posedge mclk);
        chk(32'(pin_i), 32'h0);
        chk(32'(mrst), 32'h1);
        repeat (8000) @(posedge mclk);
        chk(32'(pin_i), 32'h0);
        rd_m(OFS_STATUS, 32'h10, 32'h10);
        wake_req <= 1'b1;
        wait_pin(1'b1);
        repeat (POR_CYCLES - 1) @(posedge mclk);
        chk(32'(mrst), 32'h1);
        repeat (1) @(posedge mclk);
        chk(32'(mrst), 32'h0);
        wake_req <= 1'b0;
        rd_m(OFS_STATUS, 32'h2, 32'h2);
        // timed wake: counter loaded onto match one, match zero left behind
        wr(OFS_LOAD, 32'h0000_0003);
        settle();
        rd_m(OFS_COUNTER, 32'hFFFF_FFFF, 32'h3);
        wr(OFS_STATUS, 32'h7F);
        wr(OFS_CONTROL, 32'h96);
        repeat (2) @(posedge mclk);
        chk(32'(oe_n), 32'h0);
        wait_pin(1'b1);
        rd_m(OFS_STATUS, 32'hE, 32'h8);
        finish_test();
    end
endmodule // tb_hpc_top
`default_nettype wire
